// [src/ctm_timer.sv]
// Purpose: 10-bit compact timer with compare, timer/counter and PWM modes
// Assumes: single clock, register port with one-cycle read latency
// Notes:   timer clock is clock_i divided by 1, 4, 16 or 64
//
// Overview of operation
// - cclr low: clear on P or overflow
// - cclr high: clear on A, no P flag
// - compare A zero: overflow, no A flag
// - compare pin changes only on comparator A flag or enable rise
// - pin function sets high, low, toggle, none
// - enable rise loads pin initial level
// - mode 11 like compare, pin undriven
// - mode 10 PWM, clear select ignored
// - swap low: period field, duty compare A
// - swap high: period compare A, duty field
// - duty at least period gives full duty
// - PWM raises A and P flags
// - level select, pin function, output invert
// - PWM runs while pin forced
// - enable rise zeroes; fall and pause hold
// - period field meets top three bits
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.svh"

module ctm_timer (
   input  wire logic        clock_i,
   input  wire logic        sys_rst_i,
   input  wire logic [2:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output var  logic [15:0] reg_rdata_o,
   output var  logic        irq_o,
   output var  logic        timer_pin_o,
   output var  logic        timer_pin_oe_o
);

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [6:0]  ctrl0;
   logic [7:0]  ctrl1;
   logic [9:0]  compare_a_value;
   logic [1:0]  irq_mask;
   logic [1:0]  irq_status;
   logic [15:0] rdata;
   logic [6:0]  next_ctrl0;
   logic [7:0]  next_ctrl1;
   logic [9:0]  next_compare_a_value;
   logic [1:0]  next_irq_mask;
   logic [1:0]  next_irq_status;
   logic [15:0] next_rdata;

   logic [9:0]  count;
   logic [5:0]  prescale;
   logic        enable_q;
   logic        cmp_pin;
   logic        pin;
   logic        pin_oe;
   logic [9:0]  next_count;
   logic [5:0]  next_prescale;
   logic        next_enable_q;
   logic        next_cmp_pin;
   logic        next_pin;
   logic        next_pin_oe;

   // ****************************************************************
   // field decode
   // ****************************************************************
   ctm_pkg::ctm_mode_type mode;
   ctm_pkg::ctm_io_type   pin_func;
   logic [2:0]  period_field;
   logic        timer_enable_bit;
   logic        count_pause;
   logic        clear_source_sel;
   logic        duty_period_swap;
   logic        output_invert;
   logic        output_initial_level;
   logic [5:0]  tick_mask;

   assign mode             = ctm_pkg::ctm_mode_type'(ctrl1[`CTM_C1_MODE]);
   assign pin_func         = ctm_pkg::ctm_io_type'(ctrl1[`CTM_C1_IO]);
   assign period_field     = ctrl0[`CTM_C0_RP];
   assign timer_enable_bit = ctrl0[`CTM_C0_EN];
   assign count_pause      = ctrl0[`CTM_C0_PAUSE];
   assign clear_source_sel = ctrl1[`CTM_C1_CCLR];
   assign duty_period_swap = ctrl1[`CTM_C1_DPX];
   assign output_invert    = ctrl1[`CTM_C1_POL];
   assign output_initial_level = ctrl1[`CTM_C1_OC];

   always_comb begin
      case (ctrl0[`CTM_C0_CKSEL])
         2'h0:    tick_mask = `CTM_TICK_DIV1;
         2'h1:    tick_mask = `CTM_TICK_DIV4;
         2'h2:    tick_mask = `CTM_TICK_DIV16;
         default: tick_mask = `CTM_TICK_DIV64;
      endcase
   end

   // ****************************************************************
   // comparators
   // ****************************************************************
   logic        enable_rise;
   logic        tick;
   logic        advance;
   logic [9:0]  count_inc;
   logic        a_match;
   logic        p_match;
   logic        is_pwm;
   logic        counter_clear;
   logic        a_set;
   logic        p_set;
   logic [10:0] duty_value;
   logic [10:0] period_value;
   logic        duty_full;
   logic        pwm_active;
   logic        pwm_level;

   assign enable_rise = timer_enable_bit & ~enable_q;
   assign tick        = (prescale & tick_mask) == tick_mask;
   // PWM core independent of pin function
   assign advance     = timer_enable_bit & enable_q & ~count_pause & tick;
   assign count_inc   = count + 10'h001;
   // period field vs top three bits
   assign p_match     = (count_inc[6:0] == 7'h00) &&
                        (count_inc[9:7] == period_field);
   assign a_match     = (count_inc == compare_a_value) &&
                        (compare_a_value != `CTM_RST_CMPA);
   assign is_pwm      = (mode == ctm_pkg::ctm_mode_pwm);

   always_comb begin
      if (is_pwm) begin
         // clear chosen by swap bit only
         counter_clear = duty_period_swap ? a_match : p_match;
      end else begin
         counter_clear = clear_source_sel ? a_match : p_match;
      end
   end

   // no P flag with clear select high outside PWM
   assign a_set = advance & a_match;
   assign p_set = advance & p_match & (is_pwm | ~clear_source_sel);

   // ****************************************************************
   // pwm waveform
   // ****************************************************************
   always_comb begin
      if (duty_period_swap) begin
         period_value = (compare_a_value == `CTM_RST_CMPA) ?
                        `CTM_FULL_SPAN : {1'b0, compare_a_value};
         duty_value   = (period_field == 3'h0) ?
                        `CTM_FULL_SPAN : {1'b0, period_field, 7'h00};
      end else begin
         period_value = (period_field == 3'h0) ?
                        `CTM_FULL_SPAN : {1'b0, period_field, 7'h00};
         duty_value   = {1'b0, compare_a_value};
      end
   end

   // full duty when duty reaches period
   assign duty_full  = duty_value >= period_value;
   assign pwm_active = duty_full | ({1'b0, count} < duty_value);

   always_comb begin
      case (pin_func)
         ctm_pkg::ctm_io_f1: pwm_level = output_initial_level;
         ctm_pkg::ctm_io_f2: pwm_level = pwm_active ?
                                output_initial_level :
                                ~output_initial_level;
         default:            pwm_level = ~output_initial_level;
      endcase
   end

   // ****************************************************************
   // timer state
   // ****************************************************************
   always_comb begin
      next_prescale = prescale + 6'h01;
      next_enable_q = timer_enable_bit;
      next_count    = count;
      next_cmp_pin  = cmp_pin;
      next_pin      = 1'b0;
      next_pin_oe   = 1'b0;
      if (enable_rise) begin
         next_count = 10'h000;
      end else if (advance) begin
         next_count = counter_clear ? 10'h000 : count_inc;
      end
      if (enable_rise) begin
         next_cmp_pin = output_initial_level;
      end else if (a_set && !is_pwm) begin
         case (pin_func)
            ctm_pkg::ctm_io_f1: next_cmp_pin = 1'b0;
            ctm_pkg::ctm_io_f2: next_cmp_pin = 1'b1;
            ctm_pkg::ctm_io_f3: next_cmp_pin = ~cmp_pin;
            default:            next_cmp_pin = cmp_pin;
         endcase
      end
      case (mode)
         ctm_pkg::ctm_mode_cmp: begin
            next_pin    = next_cmp_pin ^ output_invert;
            next_pin_oe = 1'b1;
         end
         ctm_pkg::ctm_mode_pwm: begin
            next_pin    = pwm_level ^ output_invert;
            next_pin_oe = 1'b1;
         end
         default: begin
            next_pin    = 1'b0;
            next_pin_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         count    <= 10'h000;
         prescale <= 6'h00;
         enable_q <= 1'b0;
         cmp_pin  <= 1'b0;
         pin      <= 1'b0;
         pin_oe   <= 1'b0;
      end else begin
         count    <= next_count;
         prescale <= next_prescale;
         enable_q <= next_enable_q;
         cmp_pin  <= next_cmp_pin;
         pin      <= next_pin;
         pin_oe   <= next_pin_oe;
      end
   end

   // ****************************************************************
   // register port
   // ****************************************************************
   always_comb begin
      next_ctrl0           = ctrl0;
      next_ctrl1           = ctrl1;
      next_compare_a_value = compare_a_value;
      next_irq_mask        = irq_mask;
      next_rdata           = 16'h0000;
      next_irq_status      = irq_status;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `CTM_OFF_CTRL0:  next_ctrl0 = reg_wdata_i[6:0];
            `CTM_OFF_CTRL1:  next_ctrl1 = reg_wdata_i[7:0];
            `CTM_OFF_CMPA:   next_compare_a_value = reg_wdata_i[9:0];
            `CTM_OFF_MASK:   next_irq_mask = reg_wdata_i[1:0];
            default:         next_irq_mask = irq_mask;
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            `CTM_OFF_CTRL0:  next_rdata = {9'h000, ctrl0};
            `CTM_OFF_CTRL1:  next_rdata = {8'h00, ctrl1};
            `CTM_OFF_CMPA:   next_rdata = {6'h00, compare_a_value};
            `CTM_OFF_COUNT:  next_rdata = {6'h00, count};
            `CTM_OFF_STATUS: next_rdata = {14'h0000, irq_status};
            `CTM_OFF_MASK:   next_rdata = {14'h0000, irq_mask};
            default:         next_rdata = 16'h0000;
         endcase
         if (reg_addr_i == `CTM_OFF_STATUS) begin
            next_irq_status = `CTM_RST_FLAGS;
         end
      end
      // new events win over the read clear
      next_irq_status[`CTM_ST_A] = next_irq_status[`CTM_ST_A] | a_set;
      next_irq_status[`CTM_ST_P] = next_irq_status[`CTM_ST_P] | p_set;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ctrl0           <= `CTM_RST_CTRL0;
         ctrl1           <= `CTM_RST_CTRL1;
         compare_a_value <= `CTM_RST_CMPA;
         irq_mask        <= `CTM_RST_FLAGS;
         irq_status      <= `CTM_RST_FLAGS;
         rdata           <= 16'h0000;
      end else begin
         ctrl0           <= next_ctrl0;
         ctrl1           <= next_ctrl1;
         compare_a_value <= next_compare_a_value;
         irq_mask        <= next_irq_mask;
         irq_status      <= next_irq_status;
         rdata           <= next_rdata;
      end
   end

   assign reg_rdata_o    = rdata;
   assign irq_o          = |(irq_status & irq_mask);
   assign timer_pin_o    = pin;
   assign timer_pin_oe_o = pin_oe;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_enable_rise;
      !enable_q ##0 timer_enable_bit;
   endsequence

   sequence s_count_zero;
      count == 10'h000;
   endsequence

   property p_enable_zero;
      s_enable_rise |=> s_count_zero;
   endproperty
   a_enable_zero: assert property (p_enable_zero)
      else $error("counter not zeroed on enable rise");

   property p_pause_hold;
      (enable_q && timer_enable_bit && count_pause) |=> $stable(count);
   endproperty
   a_pause_hold: assert property (p_pause_hold)
      else $error("counter moved while paused");

   property p_p_clear;
      (advance && !is_pwm && !clear_source_sel && p_match)
         |=> s_count_zero;
   endproperty
   a_p_clear: assert property (p_p_clear)
      else $error("comparator P match did not clear");

   property p_no_p_flag;
      (!is_pwm && clear_source_sel) |-> !p_set;
   endproperty
   a_no_p_flag: assert property (p_no_p_flag)
      else $error("P flag raised with clear select high");

   property p_ovf_no_a;
      (advance && count == `CTM_CNT_MAX &&
       compare_a_value == `CTM_RST_CMPA) |-> !a_set ##1 s_count_zero;
   endproperty
   a_ovf_no_a: assert property (p_ovf_no_a)
      else $error("overflow handling wrong with zero compare");

   property p_set_high;
      (a_set && mode == ctm_pkg::ctm_mode_cmp &&
       pin_func == ctm_pkg::ctm_io_f2 && !output_invert)
         |=> (timer_pin_o && timer_pin_oe_o);
   endproperty
   a_set_high: assert property (p_set_high)
      else $error("pin not driven high on A match");

   property p_initial_level;
      (s_enable_rise ##0 mode == ctm_pkg::ctm_mode_cmp &&
       !output_invert) |=> (timer_pin_o == $past(output_initial_level));
   endproperty
   a_initial_level: assert property (p_initial_level)
      else $error("pin not at initial level after enable");

   property p_tc_free;
      (mode == ctm_pkg::ctm_mode_tc) |=> !timer_pin_oe_o;
   endproperty
   a_tc_free: assert property (p_tc_free)
      else $error("pin driven in timer/counter mode");

   property p_full_duty;
      (is_pwm && duty_full && pin_func == ctm_pkg::ctm_io_f2)
         |=> (timer_pin_o ==
              ($past(output_initial_level) ^ $past(output_invert)));
   endproperty
   a_full_duty: assert property (p_full_duty)
      else $error("full duty not held");

   property p_irq_level;
      (a_set && irq_mask[`CTM_ST_A] && !reg_wr_i) |=> irq_o;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt not raised for unmasked flag");

endmodule
`default_nettype wire

// [src/ctm_defs.svh]
// Purpose: register map, field positions, reset values and tick masks
// Assumes: 3-bit word address, 16-bit data
// Notes:   ranges are written as macros so fields read as reg[`FIELD]
`ifndef CTM_DEFS_SVH
`define CTM_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CTM_OFF_CTRL0   3'h0
`define CTM_OFF_CTRL1   3'h1
`define CTM_OFF_CMPA    3'h2
`define CTM_OFF_COUNT   3'h3
`define CTM_OFF_STATUS  3'h4
`define CTM_OFF_MASK    3'h5

// ****************************************************************
// field positions
// ****************************************************************
`define CTM_C0_RP       2:0
`define CTM_C0_EN       3
`define CTM_C0_CKSEL    5:4
`define CTM_C0_PAUSE    6
`define CTM_C1_CCLR     0
`define CTM_C1_DPX      1
`define CTM_C1_POL      2
`define CTM_C1_OC       3
`define CTM_C1_IO       5:4
`define CTM_C1_MODE     7:6
`define CTM_ST_A        0
`define CTM_ST_P        1

// ****************************************************************
// reset values and counts
// ****************************************************************
`define CTM_RST_CTRL0   7'h00
`define CTM_RST_CTRL1   8'h00
`define CTM_RST_CMPA    10'h000
`define CTM_RST_FLAGS   2'h0
`define CTM_CNT_MAX     10'h3FF
`define CTM_FULL_SPAN   11'h400
`define CTM_TICK_DIV1   6'h00
`define CTM_TICK_DIV4   6'h03
`define CTM_TICK_DIV16  6'h0F
`define CTM_TICK_DIV64  6'h3F

`endif

// [src/ctm_pkg.sv]
// Purpose: shared types of the compact timer
// Assumes: encodings match the control register fields
// Notes:   constants live in ctm_defs.svh
`default_nettype none
package ctm_pkg;
   typedef enum logic [1:0] {
      ctm_mode_cmp   = 2'h0,
      ctm_mode_undef = 2'h1,
      ctm_mode_pwm   = 2'h2,
      ctm_mode_tc    = 2'h3
   } ctm_mode_type;

   typedef enum logic [1:0] {
      ctm_io_f0 = 2'h0,
      ctm_io_f1 = 2'h1,
      ctm_io_f2 = 2'h2,
      ctm_io_f3 = 2'h3
   } ctm_io_type;
endpackage
`default_nettype wire

// [bench/test_ctm_timer.sv]
// Purpose: self-checking bench for the compact timer
// Assumes: timer clock select /1 in every run
// Notes:   read data checked by a monitor from a queue of expected words
`timescale 1ns/100ps
`default_nettype none
`include "ctm_defs.svh"

`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
      end \
   end

module test_ctm_timer;
   logic        clock_i;
   logic        sys_rst_i;
   logic [2:0]  reg_addr_i;
   logic [15:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [15:0] reg_rdata_o;
   logic        irq_o;
   logic        timer_pin_o;
   logic        timer_pin_oe_o;
   int          miscompares = 0;
   int          cmp_count   = 0;
   logic [15:0] exp_q[$];
   logic [15:0] exp_d;
   logic        rd_pend = 1'b0;

   ctm_timer dut (
      .clock_i        (clock_i),
      .sys_rst_i      (sys_rst_i),
      .reg_addr_i     (reg_addr_i),
      .reg_wdata_i    (reg_wdata_i),
      .reg_wr_i       (reg_wr_i),
      .reg_rd_i       (reg_rd_i),
      .reg_rdata_o    (reg_rdata_o),
      .irq_o          (irq_o),
      .timer_pin_o    (timer_pin_o),
      .timer_pin_oe_o (timer_pin_oe_o)
   );

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // ****************************************************************
   // read data monitor
   // ****************************************************************
   always @(posedge clock_i) begin
      rd_pend <= reg_rd_i;
   end

   always @(negedge clock_i) begin
      if (rd_pend === 1'b1) begin
         if (exp_q.size() == 0) begin
            miscompares++;
            $display("mismatch at %0t: read data with nothing expected",
                     $time);
         end else begin
            exp_d = exp_q.pop_front();
            `CHK(reg_rdata_o, exp_d)
         end
      end
   end

   // ****************************************************************
   // bus tasks and closing
   // ****************************************************************
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge clock_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      exp_q.push_back(e);
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
   endtask

   task automatic end_sim;
      $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // one timed run: set up, run n cycles, count pin high over per cycles
   task automatic run(input logic [7:0] c1, input logic [9:0] ca,
                      input logic [2:0] pf, input int n, input int per,
                      input int hi, input logic [1:0] st);
      int cnt;
      cnt = 0;
      wr(`CTM_OFF_CTRL0, 16'h0000);
      wr(`CTM_OFF_CTRL1, {8'h00, c1});
      wr(`CTM_OFF_CMPA, {6'h00, ca});
      wr(`CTM_OFF_CTRL0, {13'h0000, pf} | 16'h0008);
      repeat (n) @(posedge clock_i);
      repeat (per) begin
         @(negedge clock_i);
         cnt += int'(timer_pin_o === 1'b1);
      end
      `CHK(timer_pin_oe_o, (c1[7:6] == 2'h0) || (c1[7:6] == 2'h2))
      `CHK(cnt, hi)
      wr(`CTM_OFF_CTRL0, 16'h0000);
      rd(`CTM_OFF_STATUS, {14'h0000, st});
   endtask

   initial begin
      #1_000_000;
      miscompares++;
      $display("mismatch at %0t: run did not finish", $time);
      end_sim;
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [15:0] d;
      logic [1:0]  fn;
      logic        oc;
      logic        ep;
      sys_rst_i   = 1'b1;
      reg_wr_i    = 1'b0;
      reg_rd_i    = 1'b0;
      reg_addr_i  = 3'h0;
      reg_wdata_i = 16'h0000;
      void'($urandom(32'hb94b));
      repeat (12) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(negedge clock_i);
      `CHK(timer_pin_oe_o, 1'b0)
      `CHK(irq_o, 1'b0)
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), 16'h0000);
      end
      // random register traffic, counter stays off
      for (int k = 0; k < 8; k++) begin
         d = 16'($urandom());
         wr(`CTM_OFF_CTRL0, d & 16'hFFF7);
         rd(`CTM_OFF_CTRL0, d & 16'h0077);
         wr(`CTM_OFF_CTRL1, d);
         rd(`CTM_OFF_CTRL1, d & 16'h00FF);
         wr(`CTM_OFF_CMPA, d);
         rd(`CTM_OFF_CMPA, d & 16'h03FF);
         wr(`CTM_OFF_MASK, d);
         rd(`CTM_OFF_MASK, d & 16'h0003);
         wr(`CTM_OFF_COUNT, d);
         rd(`CTM_OFF_COUNT, 16'h0000);
         wr(3'h6, d);
         rd(3'h6, 16'h0000);
      end
      // compare mode: every pin function
      for (int i = 0; i < 4; i++) begin
         fn = 2'(i);
         oc = ~fn[1];
         ep = (fn == 2'h0) ? oc : (fn == 2'h1) ? 1'b0 :
              (fn == 2'h2) ? 1'b1 : ~oc;
         wr(`CTM_OFF_CTRL0, 16'h0000);
         wr(`CTM_OFF_MASK, (i == 3) ? 16'h0002 : 16'h0001);
         wr(`CTM_OFF_CTRL1, {8'h00, 2'h0, fn, oc, 3'h0});
         wr(`CTM_OFF_CMPA, 16'h0003);
         wr(`CTM_OFF_CTRL0, 16'h0009);
         @(posedge clock_i);
         @(negedge clock_i);
         `CHK(timer_pin_o, oc)
         repeat (10) @(posedge clock_i);
         @(negedge clock_i);
         `CHK(timer_pin_o, ep)
         `CHK(irq_o, 1'(i != 3))
         rd(`CTM_OFF_STATUS, 16'h0001);
         @(negedge clock_i);
         `CHK(irq_o, 1'b0)
      end
      run(8'h00, 10'h003, 3'h1, 140, 0, 0, 2'h3);
      run(8'h00, 10'h000, 3'h0, 1040, 0, 0, 2'h2);
      run(8'h01, 10'h0C8, 3'h1, 450, 0, 0, 2'h1);
      run(8'h01, 10'h000, 3'h1, 1100, 0, 0, 2'h0);
      run(8'hC0, 10'h003, 3'h1, 140, 0, 0, 2'h3);
      run(8'hA9, 10'h020, 3'h1, 300, 128, 32, 2'h3);
      run(8'hAA, 10'h100, 3'h1, 600, 256, 128, 2'h3);
      run(8'hA8, 10'h0C8, 3'h1, 300, 128, 128, 2'h2);
      run(8'hA0, 10'h020, 3'h1, 300, 128, 96, 2'h3);
      run(8'hAC, 10'h020, 3'h1, 300, 128, 96, 2'h3);
      run(8'h88, 10'h020, 3'h1, 300, 128, 0, 2'h3);
      run(8'h98, 10'h020, 3'h1, 300, 128, 128, 2'h3);
      run(8'h40, 10'h003, 3'h1, 140, 0, 0, 2'h3);
      run(8'h14, 10'h003, 3'h1, 140, 128, 128, 2'h3);
      // enable rise zeroes a used counter, pause holds it
      wr(`CTM_OFF_CTRL0, 16'h0009);
      repeat (30) @(posedge clock_i);
      wr(`CTM_OFF_CTRL0, 16'h0000);
      rd(`CTM_OFF_COUNT, 16'h001F);
      wr(`CTM_OFF_CTRL0, 16'h0049);
      repeat (20) @(posedge clock_i);
      rd(`CTM_OFF_COUNT, 16'h0000);
      for (int k = 0; k < 10 && exp_q.size() != 0; k++) begin
         @(posedge clock_i);
      end
      if (exp_q.size() != 0) begin
         miscompares++;
         $display("mismatch at %0t: read data never came", $time);
      end
      end_sim;
   end
endmodule
`default_nettype wire
